// ---- design/cte_pkg.sv ----
// constants, types and register map of the 4-bit execution core
// assumes one clock, synchronous reset, APB register access
// Contract
// - pointer-pair load sets X and Y; directly following repeats are skipped
// - Y increment variants add one and skip when Y wraps to 0
// - Y decrement variants subtract one and skip when Y becomes 15
// - reading D puts D in A bits 2..0, A bit 3 cleared
// - writing D copies A bits 2..0 into D
// - reading Z puts Z in A bits 1..0, A bits 3..2 cleared
// - reading the stack pointer puts it in A bits 2..0, bit 3 zero
// - E written as B high, A low; read back the same way
// - memory-accumulator moves first, then X becomes X xor immediate
// - accumulator immediate load; directly following repeats are skipped
// - table read takes three cycles, one stack level, loads B and A
// - with upper-bits flag set, table read loads D from ROM bits 9..8
// - add-memory sums A and memory, carry unchanged
// - add-memory-with-carry sums A, memory, carry; carry out kept
// - add-immediate leaves carry, skips when no overflow
// - AND and OR combine A with memory into A
// - set-carry forces carry to 1, clear-carry forces it to 0
// - carry test skips when carry is 0, carry unchanged
// - complement inverts A; rotate-right shifts carry:A right through carry
// - memory bit j set, clear, or test skipping when bit is 0
// - returns pop PC and decrement SP; plain and skip return take two cycles
// - short call pushes PC, jumps to page 2 at the immediate address
// - two-word compare skips when A equals the immediate
// - one-word branch changes only the in-page PC bits
package cte_pkg;
   localparam int          PC_W       = 14;
   localparam logic [6:0]  PAGE_TWO   = 7'h02;
   localparam logic [2:0]  SP_RESET   = 3'h7;
   // register map, byte addresses
   localparam logic [11:0] ADDR_CTRL  = 12'h000;
   localparam logic [11:0] ADDR_CORE  = 12'h004;
   localparam logic [11:0] ADDR_PC    = 12'h008;
   localparam int          CTRL_RUN   = 0;
   localparam int          CTRL_UPF   = 1;
   localparam logic [1:0]  CTRL_RESET = 2'h1;
   // opcodes and decode masks
   localparam logic [9:0] M_ALL = 10'h3FF, M_J2 = 10'h3FC, M_N4 = 10'h3F0;
   localparam logic [9:0] M_T2 = 10'h300, M_T3 = 10'h380, M_T4 = 10'h3C0;
   localparam logic [9:0] M_T5 = 10'h3E0;
   localparam logic [9:0] OP_TAB = 10'h01E, OP_TBA = 10'h00E;
   localparam logic [9:0] OP_TAY = 10'h01F, OP_TYA = 10'h00C;
   localparam logic [9:0] OP_WRITE_E = 10'h01A, OP_READ_E = 10'h02A;
   localparam logic [9:0] OP_WRITE_D = 10'h029, OP_READ_D = 10'h051;
   localparam logic [9:0] OP_READ_Z = 10'h053, OP_TAX = 10'h052;
   localparam logic [9:0] OP_READ_SP = 10'h050, OP_LOAD_PAIR = 10'h300;
   localparam logic [9:0] OP_LZ = 10'h048, OP_INC_Y = 10'h013;
   localparam logic [9:0] OP_DEC_Y = 10'h017, OP_LOAD_MEM = 10'h2C0;
   localparam logic [9:0] OP_XCHG = 10'h2D0, OP_XCHG_DEC = 10'h2F0;
   localparam logic [9:0] OP_XCHG_INC = 10'h2E0, OP_STORE_MEM = 10'h2B0;
   localparam logic [9:0] OP_LOAD_IMM = 10'h070, OP_TABLE = 10'h080;
   localparam logic [9:0] OP_ADD_MEM = 10'h00A, OP_ADD_MEMC = 10'h00B;
   localparam logic [9:0] OP_AN = 10'h060, OP_AND = 10'h018;
   localparam logic [9:0] OP_OR = 10'h019, OP_SET_CARRY = 10'h007;
   localparam logic [9:0] OP_CLR_CARRY = 10'h006, OP_SKIP_NC = 10'h02F;
   localparam logic [9:0] OP_COMPL = 10'h01C, OP_ROT_RIGHT = 10'h01D;
   localparam logic [9:0] OP_SET_BIT = 10'h05C, OP_CLR_BIT = 10'h04C;
   localparam logic [9:0] OP_SKIP_BIT = 10'h020, OP_SEAM = 10'h026;
   localparam logic [9:0] OP_SEAN = 10'h025, OP_B = 10'h180;
   localparam logic [9:0] OP_BL = 10'h0E0, OP_BLA = 10'h010;
   localparam logic [9:0] OP_CALL_P2 = 10'h100, OP_BML = 10'h0C0;
   localparam logic [9:0] OP_BMLA = 10'h030, OP_RET_INT = 10'h046;
   localparam logic [9:0] OP_RET = 10'h044, OP_RET_SKIP = 10'h045;

   typedef enum logic [4:0] {
      ST_EXEC  = 5'h01,
      ST_WORD2 = 5'h02,
      ST_TAB2  = 5'h04,
      ST_TAB3  = 5'h08,
      ST_RET2  = 5'h10
   } cte_state_type;

   // architectural snapshot as read on the core status register
   typedef struct packed {
      logic [5:0] zero;
      logic       skip;
      logic       carry;
      logic [2:0] sp;
      logic [2:0] d;
      logic [1:0] z;
      logic [3:0] y;
      logic [3:0] x;
      logic [3:0] b;
      logic [3:0] a;
   } cte_snap_type;
endpackage : cte_pkg

// ---- design/cte_core.sv ----
// execution core: transfers, ALU, bit ops, table read, skips, calls
// assumes a ROM that answers combinationally to romAddr; data RAM inside
`timescale 1ns/1ps
`default_nettype none
module cte_core (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst,
   // program ROM
   output logic [13:0]      romAddr,
   input  wire logic [9:0]  romData,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr
);
   function automatic logic opIs(input logic [9:0] w, input logic [9:0] op,
                                 input logic [9:0] m);
      opIs = (w & m) == op;
   endfunction : opIs

   cte_pkg::cte_state_type stateQ, stateD;
   logic [3:0]  accQ, accD, bQ, bD, xQ, xD, yQ, yD;
   logic [1:0]  zQ, zD;
   logic [2:0]  dQ, dD, spQ, spD;
   logic [7:0]  eQ, eD;
   logic        carryQ, carryD, skipQ, skipD, wSkipQ, wSkipD;
   logic        immRunQ, immRunD, pairRunQ, pairRunD;
   logic [9:0]  firstQ, firstD;
   logic [13:0] pcQ, pcD;
   logic [1:0]  ctrlQ;
   logic [13:0] stackQ [0:7];
   logic [3:0]  ramQ [0:1023];

   // shared decode
   wire logic [9:0]  instr    = romData;
   wire logic [9:0]  dataPtr  = {zQ, xQ, yQ};
   wire logic [3:0]  memNib   = ramQ[dataPtr];
   wire logic [13:0] pcNext   = pcQ + 14'h0001;
   wire logic [13:0] stackTop = stackQ[spQ];
   wire logic [2:0]  spUp     = spQ + 3'h1;
   wire logic [2:0]  spDown   = spQ - 3'h1;
   wire logic [3:0]  yInc     = yQ + 4'h1;
   wire logic [3:0]  yDec     = yQ - 4'h1;
   wire logic        runEn    = ctrlQ[cte_pkg::CTRL_RUN];
   wire logic        upfEn    = ctrlQ[cte_pkg::CTRL_UPF];
   wire logic        isLdImm  = opIs(instr, cte_pkg::OP_LOAD_IMM,
                                     cte_pkg::M_N4);
   wire logic        isPair   = opIs(instr, cte_pkg::OP_LOAD_PAIR,
                                     cte_pkg::M_T2);
   wire logic        isSean   = opIs(instr, cte_pkg::OP_SEAN, cte_pkg::M_ALL);
   wire logic        isBl     = opIs(instr, cte_pkg::OP_BL, cte_pkg::M_T5);
   wire logic        isBla    = opIs(instr, cte_pkg::OP_BLA, cte_pkg::M_ALL);
   wire logic        isBml    = opIs(instr, cte_pkg::OP_BML, cte_pkg::M_T5);
   wire logic        isBmla   = opIs(instr, cte_pkg::OP_BMLA, cte_pkg::M_ALL);
   wire logic        isTwo    = isSean | isBl | isBla | isBml | isBmla;
   wire logic        execNow  = runEn && stateQ == cte_pkg::ST_EXEC && !skipQ;
   wire logic [4:0]  addImm   = {1'b0, accQ} + {1'b0, instr[3:0]};
   wire logic [4:0]  addMem   = {1'b0, accQ} + {1'b0, memNib};
   wire logic [4:0]  addMemC  = addMem + {4'h0, carryQ};
   wire logic [13:0] longPc   = {instr[8:7], firstQ[4:0], instr[6:0]};
   wire logic [13:0] regPc    = {instr[8:6], instr[3:0], dQ, accQ};

   logic        pushEn, ramWe;
   logic [3:0]  ramWdata;

   always_comb
   begin
      stateD = stateQ;
      accD = accQ; bD = bQ; xD = xQ; yD = yQ; zD = zQ; dD = dQ;
      eD = eQ; spD = spQ; carryD = carryQ; skipD = skipQ; wSkipD = wSkipQ;
      immRunD = immRunQ; pairRunD = pairRunQ; firstD = firstQ; pcD = pcQ;
      pushEn = 1'b0;
      ramWe = 1'b0;
      ramWdata = accQ;
      if (runEn)
      begin
         case (stateQ)
            cte_pkg::ST_EXEC:
            begin
               pcD = pcNext;
               skipD = 1'b0;
               immRunD = isLdImm;
               pairRunD = isPair;
               firstD = instr;
               if (skipQ)
               begin
                  if (isTwo)
                  begin
                     stateD = cte_pkg::ST_WORD2;
                     wSkipD = 1'b1;
                  end
               end
               else if (isTwo)
               begin
                  stateD = cte_pkg::ST_WORD2;
                  wSkipD = 1'b0;
               end
               else if (isPair)
               begin
                  if (!pairRunQ)
                  begin
                     xD = instr[7:4];
                     yD = instr[3:0];
                  end
               end
               else if (isLdImm)
               begin
                  if (!immRunQ)
                     accD = instr[3:0];
               end
               else if (opIs(instr, cte_pkg::OP_TAB, cte_pkg::M_ALL))
                  accD = bQ;
               else if (opIs(instr, cte_pkg::OP_TBA, cte_pkg::M_ALL))
                  bD = accQ;
               else if (opIs(instr, cte_pkg::OP_TAY, cte_pkg::M_ALL))
                  accD = yQ;
               else if (opIs(instr, cte_pkg::OP_TYA, cte_pkg::M_ALL))
                  yD = accQ;
               else if (opIs(instr, cte_pkg::OP_TAX, cte_pkg::M_ALL))
                  accD = xQ;
               else if (opIs(instr, cte_pkg::OP_WRITE_E, cte_pkg::M_ALL))
                  eD = {bQ, accQ};
               else if (opIs(instr, cte_pkg::OP_READ_E, cte_pkg::M_ALL))
               begin
                  bD = eQ[7:4];
                  accD = eQ[3:0];
               end
               else if (opIs(instr, cte_pkg::OP_WRITE_D, cte_pkg::M_ALL))
                  dD = accQ[2:0];
               else if (opIs(instr, cte_pkg::OP_READ_D, cte_pkg::M_ALL))
                  accD = {1'b0, dQ};
               else if (opIs(instr, cte_pkg::OP_READ_Z, cte_pkg::M_ALL))
                  accD = {2'h0, zQ};
               else if (opIs(instr, cte_pkg::OP_READ_SP, cte_pkg::M_ALL))
                  accD = {1'b0, spQ};
               else if (opIs(instr, cte_pkg::OP_LZ, cte_pkg::M_J2))
                  zD = instr[1:0];
               else if (opIs(instr, cte_pkg::OP_INC_Y, cte_pkg::M_ALL))
               begin
                  yD = yInc;
                  skipD = yInc == 4'h0;
               end
               else if (opIs(instr, cte_pkg::OP_DEC_Y, cte_pkg::M_ALL))
               begin
                  yD = yDec;
                  skipD = yDec == 4'hF;
               end
               else if (opIs(instr, cte_pkg::OP_LOAD_MEM, cte_pkg::M_N4))
               begin
                  accD = memNib;
                  xD = xQ ^ instr[3:0];
               end
               else if (opIs(instr, cte_pkg::OP_STORE_MEM, cte_pkg::M_N4))
               begin
                  ramWe = 1'b1;
                  xD = xQ ^ instr[3:0];
               end
               else if (opIs(instr, cte_pkg::OP_XCHG, cte_pkg::M_N4) ||
                        opIs(instr, cte_pkg::OP_XCHG_DEC, cte_pkg::M_N4) ||
                        opIs(instr, cte_pkg::OP_XCHG_INC, cte_pkg::M_N4))
               begin
                  // exchange uses the old pointer; X changes afterwards
                  ramWe = 1'b1;
                  accD = memNib;
                  xD = xQ ^ instr[3:0];
                  if (opIs(instr, cte_pkg::OP_XCHG_INC, cte_pkg::M_N4))
                  begin
                     yD = yInc;
                     skipD = yInc == 4'h0;
                  end
                  else if (opIs(instr, cte_pkg::OP_XCHG_DEC, cte_pkg::M_N4))
                  begin
                     yD = yDec;
                     skipD = yDec == 4'hF;
                  end
               end
               else if (opIs(instr, cte_pkg::OP_TABLE, cte_pkg::M_T4))
               begin
                  pushEn = 1'b1;
                  spD = spUp;
                  pcD = {1'b0, instr[5:0], dQ, accQ};
                  stateD = cte_pkg::ST_TAB2;
               end
               else if (opIs(instr, cte_pkg::OP_ADD_MEM, cte_pkg::M_ALL))
                  accD = addMem[3:0];
               else if (opIs(instr, cte_pkg::OP_ADD_MEMC, cte_pkg::M_ALL))
                  {carryD, accD} = addMemC;
               else if (opIs(instr, cte_pkg::OP_AN, cte_pkg::M_N4))
               begin
                  accD = addImm[3:0];
                  skipD = !addImm[4];
               end
               else if (opIs(instr, cte_pkg::OP_AND, cte_pkg::M_ALL))
                  accD = accQ & memNib;
               else if (opIs(instr, cte_pkg::OP_OR, cte_pkg::M_ALL))
                  accD = accQ | memNib;
               else if (opIs(instr, cte_pkg::OP_SET_CARRY, cte_pkg::M_ALL))
                  carryD = 1'b1;
               else if (opIs(instr, cte_pkg::OP_CLR_CARRY, cte_pkg::M_ALL))
                  carryD = 1'b0;
               else if (opIs(instr, cte_pkg::OP_SKIP_NC, cte_pkg::M_ALL))
                  skipD = !carryQ;
               else if (opIs(instr, cte_pkg::OP_COMPL, cte_pkg::M_ALL))
                  accD = ~accQ;
               else if (opIs(instr, cte_pkg::OP_ROT_RIGHT, cte_pkg::M_ALL))
               begin
                  accD = {carryQ, accQ[3:1]};
                  carryD = accQ[0];
               end
               else if (opIs(instr, cte_pkg::OP_SET_BIT, cte_pkg::M_J2) ||
                        opIs(instr, cte_pkg::OP_CLR_BIT, cte_pkg::M_J2))
               begin
                  ramWe = 1'b1;
                  ramWdata = memNib;
                  ramWdata[instr[1:0]] = instr[4];
               end
               else if (opIs(instr, cte_pkg::OP_SKIP_BIT, cte_pkg::M_J2))
                  skipD = !memNib[instr[1:0]];
               else if (opIs(instr, cte_pkg::OP_SEAM, cte_pkg::M_ALL))
                  skipD = accQ == memNib;
               else if (opIs(instr, cte_pkg::OP_B, cte_pkg::M_T3))
                  pcD = {pcQ[13:7], instr[6:0]};
               else if (opIs(instr, cte_pkg::OP_CALL_P2, cte_pkg::M_T3))
               begin
                  pushEn = 1'b1;
                  spD = spUp;
                  pcD = {cte_pkg::PAGE_TWO, instr[6:0]};
               end
               else if (opIs(instr, cte_pkg::OP_RET_INT, cte_pkg::M_ALL))
               begin
                  pcD = stackTop;
                  spD = spDown;
               end
               else if (opIs(instr, cte_pkg::OP_RET, cte_pkg::M_ALL) ||
                        opIs(instr, cte_pkg::OP_RET_SKIP, cte_pkg::M_ALL))
               begin
                  pcD = stackTop;
                  spD = spDown;
                  skipD = instr[0];
                  stateD = cte_pkg::ST_RET2;
               end
            end
            cte_pkg::ST_WORD2:
            begin
               pcD = pcNext;
               stateD = cte_pkg::ST_EXEC;
               wSkipD = 1'b0;
               immRunD = 1'b0;
               pairRunD = 1'b0;
               if (!wSkipQ)
               begin
                  if (opIs(firstQ, cte_pkg::OP_SEAN, cte_pkg::M_ALL))
                     skipD = accQ == instr[3:0];
                  else if (opIs(firstQ, cte_pkg::OP_BL, cte_pkg::M_T5))
                     pcD = longPc;
                  else if (opIs(firstQ, cte_pkg::OP_BLA, cte_pkg::M_ALL))
                     pcD = regPc;
                  else
                  begin
                     pushEn = 1'b1;
                     spD = spUp;
                     pcD = opIs(firstQ, cte_pkg::OP_BML, cte_pkg::M_T5) ?
                           longPc : regPc;
                  end
               end
               else
                  skipD = 1'b0;
            end
            cte_pkg::ST_TAB2:
            begin
               bD = instr[7:4];
               accD = instr[3:0];
               if (upfEn)
                  dD = {1'b0, instr[9:8]};
               stateD = cte_pkg::ST_TAB3;
            end
            cte_pkg::ST_TAB3:
            begin
               pcD = stackTop;
               spD = spDown;
               stateD = cte_pkg::ST_EXEC;
            end
            cte_pkg::ST_RET2:
               stateD = cte_pkg::ST_EXEC;
            default:
               stateD = cte_pkg::ST_EXEC;
         endcase
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         stateQ <= cte_pkg::ST_EXEC;
         {accQ, bQ, xQ, yQ} <= 16'h0000;
         {zQ, dQ, eQ} <= 13'h0000;
         spQ <= cte_pkg::SP_RESET;
         {carryQ, skipQ, wSkipQ, immRunQ, pairRunQ} <= 5'h00;
         firstQ <= 10'h000;
         pcQ <= 14'h0000;
      end
      else
      begin
         stateQ <= stateD;
         {accQ, bQ, xQ, yQ} <= {accD, bD, xD, yD};
         {zQ, dQ, eQ} <= {zD, dD, eD};
         spQ <= spD;
         {carryQ, skipQ, wSkipQ, immRunQ, pairRunQ} <=
            {carryD, skipD, wSkipD, immRunD, pairRunD};
         firstQ <= firstD;
         pcQ <= pcD;
      end
   end

   // storage arrays carry no reset; contents are undefined until written
   always_ff @(posedge clk_sys)
   begin
      if (pushEn)
         stackQ[spUp] <= pcNext;
      if (ramWe)
         ramQ[dataPtr] <= ramWdata;
   end

   assign romAddr = pcQ;

   // APB slave with one wait state so read data comes from a flop
   cte_pkg::cte_snap_type snap;
   logic        readyQ, errQ;
   logic [31:0] rdataQ;
   wire logic   apbAcc   = psel && penable && !readyQ;
   wire logic   hitCtrl  = paddr == cte_pkg::ADDR_CTRL;
   wire logic   hitCore  = paddr == cte_pkg::ADDR_CORE;
   wire logic   hitPc    = paddr == cte_pkg::ADDR_PC;
   wire logic   hitAny   = hitCtrl | hitCore | hitPc;
   wire logic [31:0] rdMux = hitCtrl ? {30'h0, ctrlQ} :
                             hitCore ? snap :
                             hitPc   ? {13'h0, stateQ, pcQ} : 32'h0;

   assign snap = '{zero: 6'h00, skip: skipQ, carry: carryQ, sp: spQ, d: dQ,
                   z: zQ, y: yQ, x: xQ, b: bQ, a: accQ};

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         readyQ <= 1'b0;
         errQ <= 1'b0;
         rdataQ <= 32'h0000_0000;
         ctrlQ <= cte_pkg::CTRL_RESET;
      end
      else
      begin
         readyQ <= apbAcc;
         errQ <= apbAcc && !hitAny;
         if (apbAcc && !pwrite)
            rdataQ <= rdMux;
         // write lands at the edge where the master sees pready
         if (readyQ && psel && penable && pwrite && hitCtrl)
            ctrlQ <= pwdata[1:0];
      end
   end

   assign pready = readyQ;
   assign pslverr = readyQ && errQ;
   assign prdata = rdataQ;

   a_pair_first_load: assert property (@(posedge clk_sys) disable iff (rst)
      execNow && isPair && !pairRunQ |=> xQ == $past(instr[7:4]) &&
      yQ == $past(instr[3:0])) else $error("pointer pair not loaded");
   a_la_chain_hold: assert property (@(posedge clk_sys) disable iff (rst)
      execNow && isLdImm && immRunQ |=> $stable(accQ))
      else $error("repeated immediate load took effect");
   a_inc_wrap_skip: assert property (@(posedge clk_sys) disable iff (rst)
      execNow && opIs(instr, cte_pkg::OP_INC_Y, cte_pkg::M_ALL)
      |=> skipQ == (yQ == 4'h0)) else $error("increment skip wrong");
   a_dec_wrap_skip: assert property (@(posedge clk_sys) disable iff (rst)
      execNow && opIs(instr, cte_pkg::OP_DEC_Y, cte_pkg::M_ALL)
      |=> skipQ == (yQ == 4'hF)) else $error("decrement skip wrong");
   a_read_d_value: assert property (@(posedge clk_sys) disable iff (rst)
      execNow && opIs(instr, cte_pkg::OP_READ_D, cte_pkg::M_ALL)
      |=> accQ == {1'b0, $past(dQ)}) else $error("D read wrong");
   a_table_three_cycles: assert property (@(posedge clk_sys) disable iff (rst)
      execNow && opIs(instr, cte_pkg::OP_TABLE, cte_pkg::M_T4)
      |=> stateQ == cte_pkg::ST_TAB2 ##1 stateQ == cte_pkg::ST_TAB3
      ##1 stateQ == cte_pkg::ST_EXEC && spQ == $past(spQ, 3))
      else $error("table read sequence wrong");
   a_carry_add_sum: assert property (@(posedge clk_sys) disable iff (rst)
      execNow && opIs(instr, cte_pkg::OP_ADD_MEMC, cte_pkg::M_ALL)
      |=> {carryQ, accQ} == $past(addMemC))
      else $error("carry add wrong");
   a_return_pop_pc: assert property (@(posedge clk_sys) disable iff (rst)
      execNow && opIs(instr, cte_pkg::OP_RET, cte_pkg::M_ALL)
      |=> pcQ == $past(stackTop) && spQ == $past(spDown) &&
      stateQ == cte_pkg::ST_RET2) else $error("return pop wrong");
   a_call_page_two: assert property (@(posedge clk_sys) disable iff (rst)
      execNow && opIs(instr, cte_pkg::OP_CALL_P2, cte_pkg::M_T3)
      |=> pcQ == {cte_pkg::PAGE_TWO, $past(instr[6:0])} &&
      stackQ[spQ] == $past(pcNext)) else $error("short call wrong");
   a_skip_no_effect: assert property (@(posedge clk_sys) disable iff (rst)
      runEn && stateQ == cte_pkg::ST_EXEC && skipQ && !isTwo
      |=> $stable(accQ) && $stable(carryQ) && !skipQ)
      else $error("skipped instruction acted");
endmodule : cte_core
`default_nettype wire

// ---- tb/cte_rom_model.sv ----
// program rom model for the execution core
// assumes the bench preloads words before releasing reset
`timescale 1ns/1ps
`default_nettype none
module cte_rom_model (
   // fetch side
   input  wire logic [13:0] romAddr,
   output logic [9:0]       romData
);
   logic [9:0] mem [0:511];
   // unloaded words read as clear-carry, harmless filler
   initial
   begin
      for (int i = 0; i < 512; i++)
         mem[i] = 10'h006;
   end
   // answers at once; upper pages alias, only 512 words modelled
   assign romData = mem[romAddr[8:0]];
endmodule : cte_rom_model
`default_nettype wire

// ---- tb/tb_cpu4_transfer_alu_branch_exec.sv ----
// bench for the execution core: runs small programs, reads state over apb
// assumes cte_pkg register map and a combinational rom model
`timescale 1ns/1ps
`default_nettype none
module tb_cpu4_transfer_alu_branch_exec;
   logic        clk_sys = 1'h0;
   logic        rst = 1'h1;
   logic        psel = 1'h0;
   logic        penable = 1'h0;
   logic        pwrite = 1'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [13:0] romAddr;
   logic [9:0]  romData;
   int          err_total = 0;
   int          compares = 0;
   int          cyc = 0;
   cte_core uut (.clk_sys(clk_sys), .rst(rst), .romAddr(romAddr),
      .romData(romData), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));
   cte_rom_model rom (.romAddr(romAddr), .romData(romData));
   initial
   begin
      forever #2.5 clk_sys = ~clk_sys;
   end
   task automatic finish_test;
      $display("errors %0d compares %0d", err_total, compares);
      if (err_total == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : finish_test
   // runaway guard, both programs need well under this
   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc >= 3000)
      begin
         err_total++;
         finish_test;
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
         err_total++;
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
      @(posedge clk_sys);
      psel    <= 1'h1;
      penable <= 1'h0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk_sys);
      penable <= 1'h1;
      do
         @(posedge clk_sys);
      while (pready !== 1'h1);
      r = prdata;
      e = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
   endtask : apb
   task automatic load(input logic [9:0] w[$], input int at);
      foreach (w[i])
         rom.mem[at + i] = w[i];
   endtask : load
   task automatic do_reset;
      rst <= 1'h1;
      repeat (16) @(posedge clk_sys);
      rst <= 1'h0;
   endtask : do_reset
   // repeated loads, memory moves, adds, skip on no overflow, loop
   task automatic s_alu;
      logic [31:0] r;
      logic        e;
      load('{10'h335, 10'h311, 10'h079, 10'h072, 10'h2B0, 10'h074,
         10'h00A, 10'h007, 10'h00B, 10'h068, 10'h070, 10'h017,
         10'h029, 10'h18D}, 0);
      do_reset;
      repeat (40) @(posedge clk_sys);
      apb(1'h0, cte_pkg::ADDR_CORE, 32'h00000000, r, e);
      chk(r, {6'h00, 1'h0, 1'h1, 3'h7, 3'h7, 2'h0, 4'h4, 4'h3, 4'h0,
         4'hF});
      apb(1'h0, cte_pkg::ADDR_PC, 32'h00000000, r, e);
      chk(r, {13'h0000, 5'h01, 14'h000D});
      apb(1'h0, 12'h00C, 32'h00000000, r, e);
      chk({r[30:0], e}, 32'h00000001);
   endtask : s_alu
   // table read with upper bits, short call, stack pointer read, return
   task automatic s_table;
      logic [31:0] r;
      logic        e;
      load('{10'h006, 10'h006, 10'h006, 10'h006, 10'h006, 10'h006,
         10'h006, 10'h006, 10'h073, 10'h081, 10'h051, 10'h105,
         10'h18C}, 0);
      load('{10'h2A5}, 131);
      load('{10'h050, 10'h044}, 261);
      do_reset;
      // flag lands long before the table read at word 9
      apb(1'h1, cte_pkg::ADDR_CTRL, 32'h00000003, r, e);
      repeat (40) @(posedge clk_sys);
      apb(1'h0, cte_pkg::ADDR_CORE, 32'h00000000, r, e);
      chk(r, {6'h00, 1'h0, 1'h0, 3'h7, 3'h2, 2'h0, 4'h0, 4'h0, 4'hA,
         4'h0});
      apb(1'h0, cte_pkg::ADDR_PC, 32'h00000000, r, e);
      chk(r, {13'h0000, 5'h01, 14'h000C});
   endtask : s_table
   initial
   begin
      // let the rom filler run first so programs are not overwritten
      @(posedge clk_sys);
      s_alu;
      s_table;
      finish_test;
   end
endmodule : tb_cpu4_transfer_alu_branch_exec
`default_nettype wire
